// [verilog/csdr_pkg.sv]
// csdr_pkg: field layout, fixed codes, commands and decode helpers for the
// 128-bit card configuration register shared by the card end and host end.
// assumes one 100 MHz clock for both ends; no other dependencies.
package csdr_pkg;
  // clock
  localparam int unsigned CLK_PERIOD_NS  = 10;                 // core_clk period
  localparam int unsigned CLK_TENTHS     = CLK_PERIOD_NS * 10; // period in 0.1 ns
  localparam int unsigned CLKD_UNIT      = 100;                // cycles per clocked step
  // field lsb positions and widths (msb first, unsigned)
  localparam int POS_STRUCT = 126, W_STRUCT = 2;
  localparam int POS_PROT   = 122, W_PROT   = 4;
  localparam int POS_ASYNC  = 112;
  localparam int POS_CLKD   = 104;
  localparam int POS_TRAN   = 96;
  localparam int POS_CCC    = 84,  W_CCC    = 12;
  localparam int POS_RDLEN  = 80;
  localparam int POS_RDPART = 79;
  localparam int POS_WRMIS  = 78;
  localparam int POS_RDMIS  = 77;
  localparam int POS_DSR    = 76;
  localparam int POS_CSIZE  = 62,  W_CSIZE  = 12;
  localparam int POS_FACTOR = 47,  W_FACTOR = 3;
  localparam int POS_WRLEN  = 22;
  localparam int POS_WRPART = 21;
  localparam int POS_COPY   = 14;
  localparam int POS_PERM   = 13;
  localparam int POS_TMP    = 12;
  localparam int POS_ECC    = 8;
  localparam int POS_CRC    = 1;
  // fixed card codes
  localparam logic [1:0]  STRUCT_V11   = 2'h1;  // structure 1.1
  localparam logic [3:0]  PROT_V14     = 4'h1;  // protocol 1.4
  localparam logic [1:0]  STRUCT_MAXOK = 2'h1;  // 2-3 reserved
  localparam logic [3:0]  PROT_MAXOK   = 4'h1;  // 2-15 reserved
  localparam logic [3:0]  LEN_MAXOK    = 4'hb;  // 12-15 reserved
  localparam logic [3:0]  LEN_512      = 4'h9;
  localparam logic [2:0]  CUR_R        = 3'h4;
  localparam logic [2:0]  CUR_W        = 3'h5;
  localparam logic [4:0]  SECTOR_CODE  = 5'h00;
  localparam logic [4:0]  WPGRP_CODE   = 5'h1f;
  localparam logic        GRP_PROT_EN  = 1'h1;
  localparam logic [1:0]  DEF_ECC      = 2'h0;
  localparam logic [2:0]  R2W_CODE     = 3'h4;  // writes take 16x read time
  localparam logic [4:0]  RSVD_LOW     = 5'h00;
  localparam logic        LAST_BIT     = 1'h1;
  // host software register offsets
  localparam logic [7:0] A_CTRL  = 8'h00;  // w: [1:0] cmd, [2] go; r: status
  localparam logic [7:0] A_PROG  = 8'h04;  // program data
  localparam logic [7:0] A_ADDR  = 8'h08;  // block address
  localparam logic [7:0] A_LEN   = 8'h0c;  // block length
  localparam logic [7:0] A_IMG0  = 8'h10;  // image bits 31:0 .. 0x1c bits 127:96
  localparam logic [7:0] A_IMG3  = 8'h1c;
  localparam logic [7:0] A_ACC   = 8'h20;  // total access cycles
  localparam logic [7:0] A_CAPLO = 8'h24;  // capacity bytes 31:0
  localparam logic [7:0] A_CAPHI = 8'h28;  // capacity bit 32
  localparam logic [7:0] A_BLKS  = 8'h2c;  // block count
  localparam logic [7:0] A_INFO  = 8'h30;  // decoded flags
  localparam int         GO_BIT  = 2;
  // commands on the link
  typedef enum logic [1:0] {
    CMD_READ_IMG = 2'b00,
    CMD_PROGRAM  = 2'b01,
    CMD_RD_BLOCK = 2'b10,
    CMD_WR_BLOCK = 2'b11
  } csdr_cmd_t;

  // mantissa in tenths (10 = 1.0); code 0 reserved
  function automatic logic [6:0] csdrMant10(input logic [3:0] c);
    case (c)
      4'h1: csdrMant10 = 7'd10;  4'h2: csdrMant10 = 7'd12;
      4'h3: csdrMant10 = 7'd13;  4'h4: csdrMant10 = 7'd15;
      4'h5: csdrMant10 = 7'd20;  4'h6: csdrMant10 = 7'd25;
      4'h7: csdrMant10 = 7'd30;  4'h8: csdrMant10 = 7'd35;
      4'h9: csdrMant10 = 7'd40;  4'ha: csdrMant10 = 7'd45;
      4'hb: csdrMant10 = 7'd50;  4'hc: csdrMant10 = 7'd55;
      4'hd: csdrMant10 = 7'd60;  4'he: csdrMant10 = 7'd70;
      4'hf: csdrMant10 = 7'd80;  default: csdrMant10 = 7'd0;
    endcase
  endfunction

  // time exponent in ns: 1 ns .. 10 ms in decades
  function automatic logic [31:0] csdrPow10(input logic [2:0] e);
    case (e)
      3'h0: csdrPow10 = 32'd1;       3'h1: csdrPow10 = 32'd10;
      3'h2: csdrPow10 = 32'd100;     3'h3: csdrPow10 = 32'd1000;
      3'h4: csdrPow10 = 32'd10000;   3'h5: csdrPow10 = 32'd100000;
      3'h6: csdrPow10 = 32'd1000000; default: csdrPow10 = 32'd10000000;
    endcase
  endfunction

  // total access time in clocks: async part rounded up plus clocked part
  function automatic logic [31:0] csdrAccessCycles(input logic [7:0] asyncByte,
                                                   input logic [7:0] clkByte);
    logic [31:0] tenths;
    tenths = 32'(csdrMant10(asyncByte[6:3])) * csdrPow10(asyncByte[2:0]);
    csdrAccessCycles = (tenths + 32'(CLK_TENTHS - 1)) / 32'(CLK_TENTHS)
                     + 32'(clkByte) * 32'(CLKD_UNIT);
  endfunction

  // block length 2^code bytes; reserved codes give 0
  function automatic logic [12:0] csdrBlockBytes(input logic [3:0] code);
    csdrBlockBytes = (code > LEN_MAXOK) ? 13'h0 : 13'(13'h1 << code);
  endfunction

  // (device size + 1) * 2^(size_factor + 2)
  function automatic logic [21:0] csdrBlockCount(input logic [11:0] csize,
                                                 input logic [2:0]  size_factor);
    // shift amount kept 4 bits wide so codes 6 and 7 do not wrap
    csdrBlockCount = 22'(22'(csize) + 22'h1) << (4'(size_factor) + 4'h2);
  endfunction

  // true when a transfer spills over a physical block boundary
  function automatic logic csdrCrosses(input logic [31:0] addr,
                                       input logic [12:0] len,
                                       input logic [3:0]  code);
    logic [12:0] bytes;
    logic [13:0] endOff;
    bytes  = csdrBlockBytes(code);
    endOff = 14'(addr[12:0] & (bytes - 13'h1)) + 14'(len);
    csdrCrosses = endOff > 14'(bytes);
  endfunction
endpackage

// [verilog/csdr_link_if.sv]
// csdr_link_if: link between the host end and the card end.
// assumes both ends share core_clk; no clocking block, plain wires.
interface csdr_link_if;
  logic                      cmdValid;  // one-cycle command strobe
  csdr_pkg::csdr_cmd_t       cmdCode;   // command
  logic [31:0]               cmdAddr;   // byte address of a block transfer
  logic [12:0]               cmdLen;    // bytes in a block transfer
  logic [15:0]               progData;  // new low 16 bits for a program
  logic                      rspValid;  // one-cycle answer strobe
  logic                      rspError;  // command refused
  logic [127:0]              rspImage;  // register contents

  modport card (input cmdValid, cmdCode, cmdAddr, cmdLen, progData,
                output rspValid, rspError, rspImage);
  modport host (output cmdValid, cmdCode, cmdAddr, cmdLen, progData,
                input rspValid, rspError, rspImage);
endinterface

// [verilog/csdr_card.sv]
// csdr_card: card end; holds the configuration register, answers reads and
// programs, and times the first data of block transfers.
// assumes the host sends one command at a time and waits for rspValid.
//
// Strobed register access and the register addresses were decided locally.
module csdr_card
  import csdr_pkg::*;
#(
  parameter logic [7:0]  ASYNC_CODE  = 8'h26,  // access time 1.5 ms
  parameter logic [7:0]  CLOCK_CODE  = 8'h00,  // clocked access steps
  parameter logic [7:0]  RATE_CODE   = 8'h2a,  // 20 Mbit/s
  parameter logic [11:0] CLASS_MASK  = 12'h1ff,
  parameter logic [11:0] SIZE_CODE   = 12'h7ff, // model dependent
  parameter logic [2:0]  FACTOR_CODE = 3'h0,    // model dependent
  parameter logic [4:0]  ERASE_GRP   = 5'h00,   // model dependent
  parameter logic [6:0]  CRC_INIT    = 7'h00    // checksum of initial contents
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // link
  csdr_link_if.card         link,
  // card status
  output logic              permProtect,  // whole card permanently protected
  output logic              tempProtect,  // whole card temporarily protected
  output logic              dataStart     // pulse: first data bit of a transfer
);
  import csdr_pkg::*;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_WAIT  = 2'b01
  } csdr_cstate_t;

  // writable low fields
  logic               copy_q, copy_d;      // 1 = non-original
  logic               perm_q, perm_d;      // permanent protect
  logic               tmp_q, tmp_d;        // temporary protect
  logic [1:0]         ecc_q, ecc_d;        // ecc in use
  logic [6:0]         crc_q, crc_d;        // checksum
  // answer and timing
  csdr_cstate_t       state_q, state_d;
  logic [31:0]        wait_q, wait_d;      // cycles left to first data
  logic               rspValid_q, rspValid_d;
  logic               rspError_q, rspError_d;
  logic [127:0]       rspImage_q, rspImage_d;
  logic               start_q, start_d;

  // full register image, msb first
  wire logic [127:0] cardSpecificData = {
    STRUCT_V11, PROT_V14, 2'h0,
    ASYNC_CODE,
    CLOCK_CODE,
    RATE_CODE,
    CLASS_MASK,
    LEN_512, 1'h1, 1'h0, 1'h0,
    1'h0,                                  // no driver stage
    2'h0, SIZE_CODE,
    CUR_R, CUR_R, CUR_W, CUR_W,
    FACTOR_CODE,
    SECTOR_CODE, ERASE_GRP, WPGRP_CODE,
    GRP_PROT_EN, DEF_ECC, R2W_CODE,
    LEN_512, 1'h0, RSVD_LOW,
    1'h0, copy_q, perm_q, tmp_q, 2'h0,
    ecc_q, crc_q, LAST_BIT
  };

  // decoded view of the image
  wire logic [3:0]  rdCode   = cardSpecificData[POS_RDLEN +: 4];
  wire logic [3:0]  wrCode   = cardSpecificData[POS_WRLEN +: 4];
  wire logic        isWrite  = (link.cmdCode == CMD_WR_BLOCK);
  wire logic [3:0]  blkCode  = isWrite ? wrCode : rdCode;
  wire logic        partOk   = isWrite ? cardSpecificData[POS_WRPART]
                                       : cardSpecificData[POS_RDPART];
  wire logic        misOk    = isWrite ? cardSpecificData[POS_WRMIS]
                                       : cardSpecificData[POS_RDMIS];
  wire logic [12:0] blkBytes = csdrBlockBytes(blkCode);
  // a full block is always legal, smaller only with the partial flag
  wire logic        lenBad   = (link.cmdLen == 13'h0) || (link.cmdLen > blkBytes) ||
                               (!partOk && (link.cmdLen != blkBytes));
  // boundary crossing refused unless allowed
  wire logic        crossBad = !misOk && csdrCrosses(link.cmdAddr, link.cmdLen, blkCode);
  wire logic        protBad  = isWrite && (perm_q || tmp_q);
  // combined access delay; writes scale by the read-to-write factor
  wire logic [31:0] rdDelay  = csdrAccessCycles(cardSpecificData[POS_ASYNC +: 8],
                                                cardSpecificData[POS_CLKD +: 8]);
  wire logic [31:0] delay    = isWrite ? (rdDelay << R2W_CODE) : rdDelay;

  // command handling and first-data timer
  always_comb begin
    copy_d     = copy_q;
    perm_d     = perm_q;
    tmp_d      = tmp_q;
    ecc_d      = ecc_q;
    crc_d      = crc_q;
    state_d    = state_q;
    wait_d     = wait_q;
    rspValid_d = 1'b0;
    rspError_d = 1'b0;
    rspImage_d = rspImage_q;
    start_d    = 1'b0;
    case (state_q)
      CS_IDLE: begin
        if (link.cmdValid) begin
          case (link.cmdCode)
            CMD_READ_IMG: begin
              rspValid_d = 1'b1;
              rspImage_d = cardSpecificData;
            end
            CMD_PROGRAM: begin
              // copy and permanent protect only ever set
              copy_d     = copy_q | link.progData[POS_COPY];
              perm_d     = perm_q | link.progData[POS_PERM];
              tmp_d      = link.progData[POS_TMP];
              ecc_d      = link.progData[POS_ECC +: 2];
              crc_d      = link.progData[POS_CRC +: 7];
              rspValid_d = 1'b1;
            end
            default: begin
              if (lenBad || crossBad || protBad) begin
                rspValid_d = 1'b1;          // refused at once
                rspError_d = 1'b1;
              end else if (delay == 32'h0) begin
                rspValid_d = 1'b1;
                start_d    = 1'b1;
              end else begin
                wait_d  = delay - 32'h1;
                state_d = CS_WAIT;
              end
            end
          endcase
        end
      end
      CS_WAIT: begin
        // commands arriving here are ignored; host must wait for the answer
        if (wait_q == 32'h0) begin
          rspValid_d = 1'b1;                // first data leaves now
          start_d    = 1'b1;
          state_d    = CS_IDLE;
        end else begin
          wait_d = wait_q - 32'h1;
        end
      end
      default: begin
        state_d = CS_IDLE;
      end
    endcase
  end

  // state registers; reset restores the stored contents
  always_ff @(posedge core_clk) begin
    if (reset) begin
      copy_q     <= 1'b1;                   // contents marked copy
      perm_q     <= 1'b0;
      tmp_q      <= 1'b0;
      ecc_q      <= 2'h0;
      crc_q      <= CRC_INIT;
      state_q    <= CS_IDLE;
      wait_q     <= 32'h0;
      rspValid_q <= 1'b0;
      rspError_q <= 1'b0;
      rspImage_q <= 128'h0;
      start_q    <= 1'b0;
    end else begin
      copy_q     <= copy_d;
      perm_q     <= perm_d;
      tmp_q      <= tmp_d;
      ecc_q      <= ecc_d;
      crc_q      <= crc_d;
      state_q    <= state_d;
      wait_q     <= wait_d;
      rspValid_q <= rspValid_d;
      rspError_q <= rspError_d;
      rspImage_q <= rspImage_d;
      start_q    <= start_d;
    end
  end

  // outputs straight from flops
  assign link.rspValid = rspValid_q;
  assign link.rspError = rspError_q;
  assign link.rspImage = rspImage_q;
  assign permProtect   = perm_q;
  assign tempProtect   = tmp_q;
  assign dataStart     = start_q;
endmodule // csdr_card

// [verilog/csdr_host.sv]
// csdr_host: host end; issues commands from software, keeps the last
// register image and decodes access time, capacity and transfer limits.
// assumes the card end answers every command with one rspValid pulse.
module csdr_host
  import csdr_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // software port
  input  wire logic [7:0]   regAddr,
  input  wire logic [31:0]  regWData,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output logic [31:0]       regRData,
  // link
  csdr_link_if.host         link
);
  import csdr_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_BUSY = 2'b01
  } csdr_hstate_t;

  csdr_hstate_t  state_q;
  logic          cmdValid_q;
  csdr_cmd_t     cmdCode_q;
  logic [31:0]   addr_q, prog_q;
  logic [12:0]   len_q;
  logic [127:0]  image_q;        // last image read
  logic          have_q;         // an image has been read
  logic          err_q;          // card refused last command
  logic          refused_q;      // host refused last go
  logic          done_q;         // sticky: last command answered
  logic [31:0]   rdata_q;

  // decode of the held image
  wire logic        structOk = image_q[POS_STRUCT +: W_STRUCT] <= STRUCT_MAXOK;
  wire logic        protOk   = image_q[POS_PROT +: W_PROT] <= PROT_MAXOK;
  wire logic [3:0]  rdCode   = image_q[POS_RDLEN +: 4];
  wire logic [3:0]  wrCode   = image_q[POS_WRLEN +: 4];
  // async part to clocks plus hundreds of clocks
  wire logic [31:0] accCyc   = csdrAccessCycles(image_q[POS_ASYNC +: 8],
                                                image_q[POS_CLKD +: 8]);
  wire logic [21:0] blkCnt   = csdrBlockCount(image_q[POS_CSIZE +: W_CSIZE],
                                              image_q[POS_FACTOR +: W_FACTOR]);
  wire logic [12:0] rdBytes  = csdrBlockBytes(rdCode);
  wire logic [32:0] capacity = 33'(33'(blkCnt) * 33'(rdBytes));
  wire logic [7:0]  rateByte = image_q[POS_TRAN +: 8];
  wire logic [11:0] classes  = image_q[POS_CCC +: W_CCC];

  // checks before a block command leaves
  wire logic [1:0]  goCmd    = regWData[1:0];
  wire logic        goWr     = (goCmd == CMD_WR_BLOCK);
  wire logic [3:0]  goLen    = goWr ? wrCode : rdCode;
  wire logic [12:0] goBytes  = csdrBlockBytes(goLen);
  wire logic        goPart   = goWr ? image_q[POS_WRPART] : image_q[POS_RDPART];
  wire logic        goMis    = goWr ? image_q[POS_WRMIS]  : image_q[POS_RDMIS];
  wire logic        lenBad   = (len_q == 13'h0) || (len_q > goBytes) ||
                               (!goPart && (len_q != goBytes));
  wire logic        crossBad = !goMis && csdrCrosses(addr_q, len_q, goLen);
  wire logic        isBlock  = goCmd[1];
  wire logic        goReq    = regWrite && (regAddr == A_CTRL) && regWData[GO_BIT];
  wire logic        goBad    = isBlock && (!have_q || lenBad || crossBad);
  wire logic        goTake   = goReq && (state_q == HS_IDLE) && !goBad;

  // read mux
  wire logic [1:0]  imgWord  = 2'(regAddr[3:2]);
  wire logic [31:0] status   = {27'h0, have_q, refused_q, err_q, done_q,
                                state_q == HS_BUSY};
  wire logic [31:0] info     = {rateByte, 4'h0, classes, 1'h0,
                                image_q[POS_DSR], structOk, protOk, rdCode};
  wire logic [31:0] rdMux    =
      (regAddr == A_CTRL)  ? status :
      (regAddr == A_PROG)  ? prog_q :
      (regAddr == A_ADDR)  ? addr_q :
      (regAddr == A_LEN)   ? 32'(len_q) :
      (regAddr >= A_IMG0 && regAddr <= A_IMG3) ? image_q[32*imgWord +: 32] :
      (regAddr == A_ACC)   ? accCyc :
      (regAddr == A_CAPLO) ? capacity[31:0] :
      (regAddr == A_CAPHI) ? 32'(capacity[32]) :
      (regAddr == A_BLKS)  ? 32'(blkCnt) :
      (regAddr == A_INFO)  ? info : 32'h0;

  // software registers and command sequencing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q    <= HS_IDLE;
      cmdValid_q <= 1'b0;
      cmdCode_q  <= CMD_READ_IMG;
      addr_q     <= 32'h0;
      prog_q     <= 32'h0;
      len_q      <= 13'h0;
      image_q    <= 128'h0;
      have_q     <= 1'b0;
      err_q      <= 1'b0;
      refused_q  <= 1'b0;
      done_q     <= 1'b0;
      rdata_q    <= 32'h0;
    end else begin
      cmdValid_q <= goTake;
      rdata_q    <= regRead ? rdMux : 32'h0;
      if (regWrite && regAddr == A_PROG) prog_q <= regWData;
      if (regWrite && regAddr == A_ADDR) addr_q <= regWData;
      if (regWrite && regAddr == A_LEN)  len_q  <= regWData[12:0];
      if (goReq) refused_q <= !goTake;     // busy or illegal transfer
      if (goTake) begin
        cmdCode_q <= csdr_cmd_t'(goCmd);
        state_q   <= HS_BUSY;
        done_q    <= 1'b0;
      end
      // answer ends the command; only one command is ever outstanding
      if (state_q == HS_BUSY && link.rspValid) begin
        state_q <= HS_IDLE;
        done_q  <= 1'b1;
        err_q   <= link.rspError;
        if (cmdCode_q == CMD_READ_IMG) begin
          image_q <= link.rspImage;
          have_q <= 1'b1;
        end
      end
    end
  end

  assign link.cmdValid = cmdValid_q;
  assign link.cmdCode  = cmdCode_q;
  assign link.cmdAddr  = addr_q;
  assign link.cmdLen   = len_q;
  assign link.progData = prog_q[15:0];
  assign regRData      = rdata_q;
endmodule // csdr_host

// [test/csdr_link_checker.sv]
// csdr_link_checker: timing and content checks on the host-card link.
// assumes a card built with ASYNC_CODE 8'h08, CLOCK_CODE 0 (one-cycle access).
module csdr_link_checker
  import csdr_pkg::*;
(
  // clock and reset
  input wire logic                core_clk,
  input wire logic                reset,
  // link
  input wire logic                cmdValid,
  input wire csdr_pkg::csdr_cmd_t cmdCode,
  input wire logic [31:0]         cmdAddr,
  input wire logic [12:0]         cmdLen,
  input wire logic                rspValid,
  input wire logic                rspError,
  input wire logic [127:0]        rspImage
);
  timeunit 1ns;
  timeprecision 1ps;
  import csdr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // aligned full block; bit 0 of the held image tells it is a real image
  wire blkCmd = cmdValid && cmdLen == 13'h200 && cmdAddr[8:0] == 9'h0;
  // last image shows neither protect bit, so a write must be taken
  wire wrOpen = rspImage[0] && rspImage[13:12] == 2'h0;

  img_answer_a: assert property (cmdValid && cmdCode == CMD_READ_IMG |=>
    rspValid && !rspError && rspImage[0]) else $error("image read not answered");
  prog_answer_a: assert property (cmdValid && cmdCode == CMD_PROGRAM |=>
    rspValid && !rspError) else $error("program not answered");
  rsp_pulse_a: assert property (rspValid |=> !rspValid)
    else $error("answer longer than one cycle");
  upper_codes_a: assert property (rspImage[0] |->
    rspImage[127:122] == 6'h11 && rspImage[83:76] == 8'h98) else $error("upper codes wrong");
  fixed_low_a: assert property (rspImage[0] |-> rspImage[31:16] == 16'h9240)
    else $error("fixed low fields wrong");
  copy_set_a: assert property (rspImage[0] |-> rspImage[14])
    else $error("copy flag back to original");
  read_time_a: assert property (blkCmd && cmdCode == CMD_RD_BLOCK |=>
    !rspValid ##1 rspValid && !rspError) else $error("block read timing wrong");
  write_time_a: assert property (blkCmd && cmdCode == CMD_WR_BLOCK && wrOpen |=>
    (!rspValid)[*8] ##1 (!rspValid)[*8] ##1 rspValid && !rspError)
    else $error("block write timing wrong");
  wr_refuse_a: assert property (cmdValid && cmdCode == CMD_WR_BLOCK && rspImage[12] |=>
    rspValid && rspError) else $error("protected write taken");
  // main scenarios seen
  cover property (rspValid && rspError);
  cover property (cmdValid && cmdCode == CMD_WR_BLOCK && wrOpen);
  cover property (cmdValid && cmdCode == CMD_PROGRAM);
endmodule // csdr_link_checker

// [test/test_card_specific_data_register.sv]
// test_card_specific_data_register: drives the host software port, checks
// image, decoded values and block admission. card uses a 1 ns access time.
module test_card_specific_data_register;
  timeunit 1ns;
  timeprecision 1ps;
  import csdr_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [31:0] regRData;
  logic [31:0] v;        // last value read
  logic        tmpProt;  // card temporary protect
  logic        permProt; // card permanent protect
  logic        dataStart; // card first-data pulse
  int          n_starts   = 0;  // first-data pulses seen
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          cyc        = 0;
  // image words 0x10..0x1c, access cycles, capacity, block count, info
  localparam logic [31:0] EXP [9] = '{32'h92404001, 32'he4b4001f, 32'h1ff981ff,
    32'h4408002a, 32'h1, 32'h400000, 32'h0, 32'h2000, 32'h2a01ff39};
  csdr_link_if link();
  csdr_card #(.ASYNC_CODE(8'h08)) csdr_card_inst (.core_clk(core_clk), .reset(reset),
    .link(link), .permProtect(permProt), .tempProtect(tmpProt), .dataStart(dataStart));
  csdr_host csdr_host_inst (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWData(regWData), .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
    .link(link));
  csdr_link_checker csdr_link_checker_inst (.core_clk(core_clk), .reset(reset),
    .cmdValid(link.cmdValid), .cmdCode(link.cmdCode), .cmdAddr(link.cmdAddr),
    .cmdLen(link.cmdLen), .rspValid(link.rspValid), .rspError(link.rspError),
    .rspImage(link.rspImage));
  always #5 core_clk = ~core_clk;
  // hang guard: the whole run needs well under this
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // count first-data pulses; only accepted block transfers make them
  always @(posedge core_clk) begin
    if (dataStart === 1'b1) n_starts++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    v = regRData;
  endtask
  // start a link command, poll until idle; v keeps the final status
  task automatic go(input logic [1:0] c);
    wr(8'h00, {29'h0, 1'b1, c});
    for (int i = 0; i < 30; i++) begin
      rd(8'h00);
      if (v[0] === 1'b0) break;
    end
  endtask
  task automatic blk(input logic [1:0] c, input logic [31:0] a, input logic [12:0] n);
    wr(8'h08, a);
    wr(8'h0c, {19'h0, n});
    go(c);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h10);
    chk(v, 32'h0);
    rd(8'hfc);
    chk(v, 32'h0);
    go(2'h0);
    chk(v, 32'h12);
    for (int i = 0; i < 9; i++) begin
      rd(8'h10 + 8'(4 * i));
      chk(v, EXP[i]);
    end
    blk(2'h2, 32'h0, 13'h200);
    chk(v & 32'h6, 32'h2);
    blk(2'h2, 32'h3ff, 13'h1);
    chk(v & 32'h6, 32'h2);
    blk(2'h3, 32'h200, 13'h200);
    chk(v & 32'h6, 32'h2);
    chk(n_starts, 32'h3);
    blk(2'h2, 32'h1ff, 13'h2);
    chk(v & 32'h8, 32'h8);
    blk(2'h3, 32'h1ff, 13'h200);
    chk(v & 32'h8, 32'h8);
    blk(2'h2, 32'h0, 13'h201);
    chk(v & 32'h8, 32'h8);
    // set temporary protect and a new checksum; bit 0 must not follow
    wr(8'h04, 32'h1080);
    go(2'h1);
    go(2'h0);
    rd(8'h10);
    chk(v, 32'h92405081);
    chk({31'h0, tmpProt}, 32'h1);
    blk(2'h3, 32'h0, 13'h200);
    chk(v & 32'h4, 32'h4);
    chk(n_starts, 32'h3);
    // set permanent protect, then clear all low bits: copy and permanent protect stay
    wr(8'h04, 32'h2000);
    go(2'h1);
    wr(8'h04, 32'h0);
    go(2'h1);
    go(2'h0);
    rd(8'h10);
    chk(v, 32'h92406001);
    chk({31'h0, permProt}, 32'h1);
    chk({31'h0, tmpProt}, 32'h0);
    end_sim();
  end
endmodule // test_card_specific_data_register
